// ===== ust_regs.vh
// Register map, field positions and reset values of the synchronous transmitter
`ifndef UST_REGS_VH
`define UST_REGS_VH
// Byte offsets on the register bus
`define UST_OFS_CTRL 8'h00
`define UST_OFS_STATUS 8'h04
`define UST_OFS_TXDATA 8'h08
`define UST_OFS_BAUD_LO 8'h0c
`define UST_OFS_BAUD_HI 8'h10
// Control register fields
`define UST_CTRL_SYNC 0
`define UST_CTRL_MSTR 1
`define UST_CTRL_PORT 2
`define UST_CTRL_RX1 3
`define UST_CTRL_RXC 4
`define UST_CTRL_TXON 5
`define UST_CTRL_NINE 6
`define UST_CTRL_BIT9 7
`define UST_CTRL_POL 8
`define UST_CTRL_WIDE 9
`define UST_CTRL_HSPD 10
`define UST_CTRL_TXINT 11
`define UST_CTRL_GLOB 12
`define UST_CTRL_PERI 13
`define UST_CTRL_W 14
// Status register fields
`define UST_STAT_EMPTY 0
`define UST_STAT_BUSY 1
`define UST_STAT_XMIT 2
// Reset values
`define UST_CTRL_RST 14'h0000
`define UST_BAUD_RST 8'h00
// Character lengths
`define UST_BITS_8 4'h8
`define UST_BITS_9 4'h9
// Bit count step, and the count that marks the final bit
`define UST_ONE_LEFT 4'h1
`endif

// ===== ust_baud_gen.v
// Baud rate generator: half-bit tick from a reloading down counter
`timescale 1ns/1ps
module ust_baud_gen #(
   parameter DIV_W = 16
)(
   input wire sys_clk, // System clock
   input wire rst, // Synchronous reset, active high
   input wire clear, // Restart the count from the divisor
   input wire [DIV_W-1:0] divisor, // Reload value
   output wire tick // One-cycle pulse per half bit
);
   reg [DIV_W-1:0] count_reg;
   reg [DIV_W-1:0] count_next;

   assign tick = ~clear & (count_reg == {DIV_W{1'b0}});

   // Down count; a clear reloads so the next half bit is a full one
   always @*
   begin
      if (clear | tick)
         count_next = divisor;
      else
         count_next = count_reg - {{(DIV_W-1){1'b0}}, 1'b1};
   end

   // Counter register
   always @(posedge sys_clk)
   begin
      if (rst)
         count_reg <= {DIV_W{1'b0}};
      else
         count_reg <= count_next;
   end
endmodule // ust_baud_gen

// ===== ust_sync_tx.v
// Synchronous master transmitter with AHB-Lite register slave
`timescale 1ns/1ps
`include "ust_regs.vh"
module ust_sync_tx #(
   parameter DIV_W = 16
)(
   input wire sys_clk, // System clock, 200 MHz
   input wire rst, // Synchronous reset, active high
   input wire hsel, // Slave select
   input wire [31:0] haddr, // Byte address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write when high
   input wire [2:0] hsize, // Transfer size, word only
   input wire [31:0] hwdata, // Write data
   input wire hready, // Bus ready
   output wire hreadyout, // Slave ready
   output wire hresp, // Always OKAY
   output wire [31:0] hrdata, // Read data
   output wire clockPinOut, // Clock pin level
   output wire clockPinOe, // Clock pin driver enable
   input wire clockPinIn, // Clock pin sensed level, unused as master
   output wire dataPinOut, // Data pin level
   output wire dataPinOe, // Data pin driver enable
   input wire dataPinIn, // Data pin sensed level, unused in transmit
   output wire txIrq // Transmit interrupt request, level
);
   // One-hot transmit states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_LEAD = 3'b010;
   localparam [2:0] ST_TRAIL = 3'b100;

   // Software visible registers
   reg [`UST_CTRL_W-1:0] ctrl_reg;
   reg [7:0] baudLo_reg;
   reg [7:0] baudHi_reg;

   // Bus data phase tracking
   reg [7:0] addr_reg;
   reg wrPend_reg;
   reg rdPend_reg;
   reg rdDone_reg;
   reg [31:0] rdata_reg;
   reg [31:0] rdata_next;

   // Transmit datapath and sequencer
   reg [8:0] hold_reg;
   reg holdFull_reg;
   reg [8:0] shift_reg;
   reg [3:0] bitsLeft_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg clkActive_reg;
   reg dataBit_reg;

   // Sequencer strobes, decoded every cycle
   reg loadShift;
   reg shiftOut;
   reg lastBit;

   // Bus decode, mode and timing nets
   wire addrPhase;
   wire wrData;
   wire wrCtrl;
   wire wrHold;
   wire wrBaudLo;
   wire wrBaudHi;
   wire masterCfg;
   wire xmitCfg;
   wire xmitRun;
   wire [DIV_W-1:0] divisor;
   wire baudClear;
   wire baudTick;
   wire holdEmpty;
   wire [3:0] charBits;
   wire inIdle;
   wire trailTick;

   // Bus address phase is taken only when the bus is ready
   assign addrPhase = hsel & htrans[1] & hready;

   // Write data is used in the data phase, one cycle after its address
   assign wrData = wrPend_reg;
   assign wrCtrl = wrData & (addr_reg == `UST_OFS_CTRL);
   assign wrHold = wrData & (addr_reg == `UST_OFS_TXDATA);
   assign wrBaudLo = wrData & (addr_reg == `UST_OFS_BAUD_LO);
   assign wrBaudHi = wrData & (addr_reg == `UST_OFS_BAUD_HI);

   // Reads take one wait state so read data comes from a flop
   assign hreadyout = ~(rdPend_reg & ~rdDone_reg);
   assign hresp = 1'b0;

   // Read data comes straight from a flop, never from the mux
   assign hrdata = rdata_reg;

   // Address phase capture and data phase tracking
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         addr_reg <= 8'h00;
         wrPend_reg <= 1'b0;
         rdPend_reg <= 1'b0;
         rdDone_reg <= 1'b0;
      end
      else
      begin
         if (hreadyout)
         begin
            addr_reg <= haddr[7:0];
            wrPend_reg <= addrPhase & hwrite;
            rdPend_reg <= addrPhase & ~hwrite;
            rdDone_reg <= 1'b0;
         end
         else
            rdDone_reg <= 1'b1;
      end
   end

   // Read mux; the shift register has no address
   always @*
   begin
      rdata_next = 32'h0000_0000;
      case (addr_reg)
         `UST_OFS_CTRL: rdata_next[`UST_CTRL_W-1:0] = ctrl_reg;
         `UST_OFS_STATUS:
         begin
            rdata_next[`UST_STAT_EMPTY] = holdEmpty;
            rdata_next[`UST_STAT_BUSY] = ~inIdle;
            rdata_next[`UST_STAT_XMIT] = xmitCfg;
         end
         `UST_OFS_BAUD_LO: rdata_next[7:0] = baudLo_reg;
         `UST_OFS_BAUD_HI: rdata_next[7:0] = baudHi_reg;
         // Unmapped offsets and the write-only data register read as zero
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data register, loaded in the wait cycle
   always @(posedge sys_clk)
   begin
      if (rst)
         rdata_reg <= 32'h0000_0000;
      else if (rdPend_reg & ~rdDone_reg)
         rdata_reg <= rdata_next;
   end

   // Control register
   always @(posedge sys_clk)
   begin
      if (rst)
         ctrl_reg <= `UST_CTRL_RST;
      else if (wrCtrl)
         ctrl_reg <= hwdata[`UST_CTRL_W-1:0];
   end

   // Divisor low byte
   always @(posedge sys_clk)
   begin
      if (rst)
         baudLo_reg <= `UST_BAUD_RST;
      else if (wrBaudLo)
         baudLo_reg <= hwdata[7:0];
   end

   // Divisor high byte, resets to zero
   always @(posedge sys_clk)
   begin
      if (rst)
         baudHi_reg <= `UST_BAUD_RST;
      else if (wrBaudHi)
         baudHi_reg <= hwdata[7:0];
   end

   // Mode decode: any receive enable selects receive instead
   assign masterCfg = ctrl_reg[`UST_CTRL_SYNC] & ctrl_reg[`UST_CTRL_MSTR]
      & ctrl_reg[`UST_CTRL_PORT];
   assign xmitCfg = masterCfg & ~ctrl_reg[`UST_CTRL_RX1]
      & ~ctrl_reg[`UST_CTRL_RXC];

   // Shifting needs transmit enable on top of the mode
   assign xmitRun = xmitCfg & ctrl_reg[`UST_CTRL_TXON];

   // Upper divisor byte only counts in wide mode
   assign divisor = ctrl_reg[`UST_CTRL_WIDE] ?
      {baudHi_reg, baudLo_reg} : {8'h00, baudLo_reg};

   // State decodes shared by the datapath and the counter clear
   assign inIdle = (state_reg == ST_IDLE);
   assign trailTick = (state_reg == ST_TRAIL) & baudTick;

   // Counter restarts on a high-byte write and while idle
   // Holding it while idle gives every character a full first half bit
   assign baudClear = wrBaudHi | inIdle;

   ust_baud_gen #(
      .DIV_W(DIV_W)
   ) baudGen (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(baudClear),
      .divisor(divisor),
      .tick(baudTick)
   );

   // Character length: eight bits, nine when selected
   assign charBits = ctrl_reg[`UST_CTRL_NINE] ? `UST_BITS_9 : `UST_BITS_8;

   // Holding register counts as empty once its character has moved on
   assign holdEmpty = ~holdFull_reg;

   // Transmit sequencer; no start or stop framing is ever added
   always @*
   begin
      state_next = state_reg;
      loadShift = 1'b0;
      shiftOut = 1'b0;
      lastBit = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            // Empty shifter takes the held character at once
            if (xmitRun & holdFull_reg)
            begin
               loadShift = 1'b1;
               state_next = ST_LEAD;
            end
         end
         ST_LEAD:
         begin
            // Leading edge: clock goes active, data bit changes
            if (baudTick)
            begin
               shiftOut = 1'b1;
               state_next = ST_TRAIL;
            end
         end
         ST_TRAIL:
         begin
            // Trailing edge ends one clock cycle per bit
            if (baudTick)
            begin
               lastBit = (bitsLeft_reg == `UST_ONE_LEFT);
               if (!lastBit)
                  state_next = ST_LEAD;
               else if (xmitRun & holdFull_reg)
               begin
                  // Waiting character goes only after the last bit
                  loadShift = 1'b1;
                  state_next = ST_LEAD;
               end
               else
                  state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // Leaving transmit configuration aborts, half-duplex only
      if (!xmitRun)
      begin
         state_next = ST_IDLE;
         loadShift = 1'b0;
         shiftOut = 1'b0;
      end
   end

   // State register
   always @(posedge sys_clk)
   begin
      if (rst)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Holding register; a write in the move cycle wins over the clear
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         hold_reg <= 9'h000;
         holdFull_reg <= 1'b0;
      end
      else if (wrHold)
      begin
         // Ninth bit is taken from control at the write
         hold_reg <= {ctrl_reg[`UST_CTRL_BIT9], hwdata[7:0]};
         holdFull_reg <= 1'b1;
      end
      else if (loadShift)
         holdFull_reg <= 1'b0;
   end

   // Hidden shift register, least significant bit out first
   always @(posedge sys_clk)
   begin
      if (rst)
         shift_reg <= 9'h000;
      else if (loadShift)
         shift_reg <= hold_reg;
      else if (shiftOut)
         shift_reg <= {1'b0, shift_reg[8:1]};
   end

   // Bits still to go; counted down at each trailing edge
   always @(posedge sys_clk)
   begin
      if (rst)
         bitsLeft_reg <= 4'h0;
      else if (loadShift)
         bitsLeft_reg <= charBits;
      else if (trailTick)
         bitsLeft_reg <= bitsLeft_reg - `UST_ONE_LEFT;
   end

   // Clock phase: active from leading to trailing edge, one cycle per bit
   always @(posedge sys_clk)
   begin
      if (rst)
         clkActive_reg <= 1'b0;
      else if (shiftOut)
         clkActive_reg <= 1'b1;
      else if (trailTick)
         clkActive_reg <= 1'b0;
      else if (!xmitRun)
         clkActive_reg <= 1'b0;
   end

   // Data bit changes only on a leading edge and holds to the next
   always @(posedge sys_clk)
   begin
      if (rst)
         dataBit_reg <= 1'b0;
      else if (shiftOut)
         dataBit_reg <= shift_reg[0];
   end

   // Idle level equals polarity; set idles high, falling leading edge
   assign clockPinOut = clkActive_reg ^ ctrl_reg[`UST_CTRL_POL];
   // Clock driver on for any synchronous master setup
   assign clockPinOe = masterCfg;
   // Data driven only in master transmit configuration
   assign dataPinOut = dataBit_reg;
   assign dataPinOe = xmitCfg;

   // Holding empty flag gated by the three enables
   assign txIrq = holdEmpty & ctrl_reg[`UST_CTRL_TXINT]
      & ctrl_reg[`UST_CTRL_GLOB] & ctrl_reg[`UST_CTRL_PERI];
endmodule // ust_sync_tx

// ===== ust_sync_tx_asserts.sv
// Checker for bus wait states, pin drivers and serial clock shape
`timescale 1ns/1ps
module ust_sync_tx_asserts (
   input wire sys_clk, // Clock
   input wire rst, // Reset
   input wire hsel, // Select
   input wire [31:0] haddr, // Address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write
   input wire [31:0] hwdata, // Write data
   input wire hready, // Bus ready
   input wire hreadyout, // Slave ready
   input wire clockPinOut, // Clock pin
   input wire clockPinOe, // Clock enable
   input wire dataPinOut, // Data pin
   input wire dataPinOe, // Data enable
   input wire txIrq // Interrupt
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   reg [13:0] ctrlReg;
   reg [7:0] loReg, hiReg, aQ;
   reg [16:0] cnt;
   reg wQ, prevClk, prevPol;
   wire taken = hsel && htrans[1] && hready;
   wire cfg = &ctrlReg[2:0];
   wire pol = ctrlReg[8];
   wire [16:0] half = (ctrlReg[9] ? {1'b0, hiReg, loReg} : {9'h0, loReg}) + 17'h1;
   wire trail = clockPinOut != prevClk && clockPinOut == pol && pol == prevPol;
   // Register shadow; pulse width depends on it, a polarity flip must not look like an edge
   always @(posedge sys_clk)
   begin
      if (taken)
         aQ <= haddr[7:0];
      wQ <= taken && hwrite;
      prevClk <= clockPinOut;
      prevPol <= pol;
      cnt <= (clockPinOut != prevClk) ? 17'h1 : cnt + 17'h1;
      if (rst)
         ctrlReg <= 14'h0;
      else if (wQ && aQ == 8'h00)
         ctrlReg <= hwdata[13:0];
      if (wQ && aQ == 8'h0c)
         loReg <= hwdata[7:0];
      if (rst || wQ && aQ == 8'h10)
         hiReg <= rst ? 8'h0 : hwdata[7:0];
   end
   property p_clk_oe; clockPinOe == cfg; endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock enable");
   property p_dat_oe; dataPinOe == (cfg && !ctrlReg[3] && !ctrlReg[4]); endproperty
   a_dat_oe: assert property (p_dat_oe) else $error("data enable");
   property p_idle; !cfg [*3] |-> clockPinOut == pol; endproperty
   a_idle: assert property (p_idle) else $error("idle level");
   property p_half; trail |-> cnt == half; endproperty
   a_half: assert property (p_half) else $error("half bit");
   property p_lead; $changed(dataPinOut) |-> clockPinOut != prevClk && clockPinOut != pol; endproperty
   a_lead: assert property (p_lead) else $error("data moved");
   property p_rd; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd: assert property (p_rd) else $error("read wait");
   property p_wr; taken && hwrite |=> hreadyout; endproperty
   a_wr: assert property (p_wr) else $error("write wait");
   property p_irq; txIrq |-> &ctrlReg[13:11]; endproperty
   a_irq: assert property (p_irq) else $error("irq gate");
endmodule // ust_sync_tx_asserts
bind ust_sync_tx ust_sync_tx_asserts u_chk (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .clockPinOut, .clockPinOe, .dataPinOut, .dataPinOe, .txIrq);

// ===== ust_slave_model.sv
// Behavioural slave that shifts in the master's characters
`timescale 1ns/1ps
module ust_slave_model (
   input wire logic clkLine, // Shared clock line
   input wire logic idlePol, // Idle clock level
   input wire logic dataLine, // Shared data line
   output logic [8:0] rxWord, // Newest bit on top
   output int rxCount // Trailing edges seen
);
   // No clock of its own: sample at the master's trailing edge, mid-bit
   always @(clkLine)
   begin
      if (clkLine === idlePol)
      begin
         rxWord = {dataLine, rxWord[8:1]};
         rxCount = rxCount + 1;
      end
   end
endmodule // ust_slave_model

// ===== usart_sync_master_tx_tb.sv
// Bench: registers, serial characters against a slave model, pin drivers
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errCount++; \
   $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module usart_sync_master_tx_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic idlePat = 1'b0;
   logic [13:0] ctrl = 14'h0;
   logic [31:0] q;
   logic [8:0] expQ[$];
   logic [8:0] rxWord;
   int rxCount;
   int seed;
   int errCount = 0;
   int nCompared = 0;
   int cycles = 0;
   wire hreadyout, hresp, clockPinOut, clockPinOe, dataPinOut, dataPinOe, txIrq;
   wire [31:0] hrdata;
   // Undriven lines wander, so a stale level never passes for data
   wire clkWire = clockPinOe ? clockPinOut : idlePat;
   wire dataWire = dataPinOe ? dataPinOut : idlePat;
   ust_sync_tx dut (.sys_clk(sys_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clockPinOut(clockPinOut),
      .clockPinOe(clockPinOe), .clockPinIn(clkWire), .dataPinOut(dataPinOut),
      .dataPinOe(dataPinOe), .dataPinIn(dataWire), .txIrq(txIrq));
   ust_slave_model rx (.clkLine(clkWire), .idlePol(ctrl[8]), .dataLine(dataWire),
      .rxWord(rxWord), .rxCount(rxCount));
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Hang guard; the full run needs about 8700 cycles
   always @(posedge sys_clk)
   begin
      idlePat <= ~idlePat;
      cycles++;
      if (cycles == 30000)
      begin
         errCount++;
         giveVerdict();
      end
   end
   task automatic giveVerdict();
      begin
         $display("compared %0d, mismatches %0d", nCompared, errCount);
         if (errCount == 0 && nCompared > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // One AHB-Lite single transfer; read data lands in q
   task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      begin
         haddr <= {24'h0, a};
         hwrite <= wr;
         htrans <= 2'b10;
         do @(posedge sys_clk); while (hreadyout !== 1'b1);
         htrans <= 2'b00;
         hwdata <= d;
         do @(posedge sys_clk); while (hreadyout !== 1'b1);
         q = hrdata;
      end
   endtask
   // Extra edge lets a polarity flip settle before counts are taken
   task automatic setCtrl(input logic [13:0] c);
      begin
         ctrl = c;
         busXfer(1'b1, 8'h00, {18'h0, c});
         @(posedge sys_clk);
      end
   endtask
   // Second write lands while the first character still shifts
   task automatic sendPair();
      int tgt;
      logic [31:0] d;
      logic [8:0] got;
      logic [8:0] want;
      begin
         tgt = rxCount;
         repeat (2)
         begin
            d = $random(seed);
            busXfer(1'b1, 8'h08, d);
            expQ.push_back({ctrl[6] & ctrl[7], d[7:0]});
         end
         repeat (2)
         begin
            tgt = tgt + (ctrl[6] ? 9 : 8);
            while (rxCount < tgt) @(posedge sys_clk);
            got = ctrl[6] ? rxWord : {1'b0, rxWord[8:1]};
            want = expQ.pop_front();
            `CHK(got, want)
         end
         repeat (8) @(posedge sys_clk);
         `CHK(rxCount, tgt)
      end
   endtask
   initial
   begin
      int r;
      logic [7:0] hi;
      seed = 32'h1bc10787;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      busXfer(1'b0, 8'h10, 32'h0);
      `CHK(q, 32'h0)
      busXfer(1'b0, 8'h20, 32'h0);
      `CHK(q, 32'h0)
      `CHK(hresp, 1'b0)
      hi = 8'($random(seed)) | 8'h01;
      busXfer(1'b1, 8'h10, {24'h0, hi});
      busXfer(1'b0, 8'h10, 32'h0);
      `CHK(q, {24'h0, hi})
      busXfer(1'b1, 8'h0c, 32'h1);
      // Both polarities, both lengths; high byte is ignored while narrow
      for (int m = 0; m < 4; m++)
      begin
         r = $random(seed);
         setCtrl({5'h0, m[0], r[0], m[1], 6'h27});
         sendPair();
      end
      setCtrl(14'h3827);
      `CHK(txIrq, 1'b1)
      setCtrl(14'h2827);
      `CHK(txIrq, 1'b0)
      setCtrl(14'h002f);
      `CHK(dataPinOe, 1'b0)
      `CHK(clockPinOe, 1'b1)
      // Wide divisor: long half bit, high byte written while idle
      busXfer(1'b1, 8'h10, 32'h1);
      setCtrl(14'h0227);
      sendPair();
      giveVerdict();
   end
endmodule // usart_sync_master_tx_tb
